// >>> design/fsps_pkg.sv
// Constants, field layouts and types of the flash self-program sequencer
package fsps_pkg;

  // Clock and programming time
  localparam int CLK_MHZ = 50;
  localparam int PROG_TIME_US = 3700;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  // Cycles after a control write in which a store or load is honoured
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  localparam logic [2:0] LOAD_WINDOW = 3'h3;

  // Flash organisation and pointer fields
  localparam int WORD_BITS = 6;
  localparam int PAGE_BITS = 7;
  localparam int PAGE_WORDS = 64;
  localparam int WORD_LSB = 1;
  localparam int PAGE_LSB = 7;
  localparam logic [6:0] RWW_PAGES = 7'h70;

  // Register byte offsets on the bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_POINTER = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_STORE = 8'h0c;
  localparam logic [7:0] OFF_LOAD = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // Control register bit positions
  localparam int BIT_IRQ_EN = 7;
  localparam int BIT_BUSY = 6;

  // Command patterns in the low five control bits
  localparam logic [4:0] CMD_NONE = 5'h00;
  localparam logic [4:0] CMD_LOAD = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_REEN = 5'h11;

  // Lock and fuse read pointers, lock reset value
  localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
  localparam logic [15:0] Z_LOCK = 16'h0001;
  localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
  localparam logic [5:0] LOCK_RESET = 6'h3f;
  localparam logic [15:0] BUF_EMPTY = 16'hffff;

  // Program-store control register image
  typedef struct packed {
    logic irq_en;
    logic busy;
    logic res;
    logic reen;
    logic lock;
    logic pwrite;
    logic erase;
    logic store_enable_bit;
  } fsps_ctrl_t;

  // Flash array command carried to the memory macro
  typedef struct packed {
    logic erase;
    logic write;
    logic [6:0] page;
  } fsps_flash_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_BUSY = 3'b100
  } fsps_state_t;

endpackage

// >>> design/fsps_sequencer.sv
// Flash self-program sequencer with AXI4-Lite register access
// How it works
// - Erase command plus store within four cycles
// - Erase halts CPU in no-READ_WHILE_WRITE_SECTION section
// - Load command stores word at word field
// - Buffer cleared after write, re-enable, reset
// - EEPROM write discards loaded buffer data
// - Write command plus store starts page write
// - Page write halts CPU in no-READ_WHILE_WRITE_SECTION section
// - Target page latched when operation starts
// - Interrupt asserted while enable bit clear
// - Busy flag blocks READ_WHILE_WRITE_SECTION reads during programming
// - Lock command programs cleared data bits 5 to 2
// - EEPROM write blocks programming and fuse reads
// - Pointer 0001 load returns lock byte
// - Lock-set and enable self-clear on timeout
// - Pointer 0000 load returns low fuses
// - Pointer 0003 load returns high fuses
// - Programmed bits read zero, unprogrammed one
// - Load selects byte with pointer bit zero
// - Enable bit stays set during operation
// - Other command patterns have no effect
// - Page load clears section busy flag
`timescale 1ns/1ns
module fsps_sequencer #(
  parameter int unsigned PROG_CYCLES = fsps_pkg::PROG_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // EEPROM status and fuse values
  input wire logic eeprom_write_busy_bit,
  input wire logic [7:0] fuse_low_byte,
  input wire logic [7:0] fuse_high_byte,
  // Flash array read port for normal loads
  output logic [12:0] flash_rd_addr,
  input wire logic [15:0] flash_rd_word,
  // Flash array command and buffer read-out
  output fsps_pkg::fsps_flash_cmd_t flash_cmd,
  input wire logic [5:0] buf_rd_addr,
  output logic [15:0] buf_rd_data,
  // CPU side indications
  output logic cpu_halt,
  output logic rww_read_blocked,
  output logic store_ready_irq
);

  fsps_pkg::fsps_state_t state_q;
  logic [4:0] cmd_q;
  logic [2:0] win_q;
  logic [2:0] load_win_q;
  logic irq_en_q;
  logic busy_flag_q;
  logic halt_q;
  logic [31:0] op_cnt_q;
  logic [6:0] page_q;
  logic op_write_q;
  logic op_erase_q;
  logic [15:0] z_q;
  logic [15:0] data_q;
  logic [5:0] lock_q;
  logic [7:0] load_q;
  logic bvalid_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [15:0] buf_mem [fsps_pkg::PAGE_WORDS];
  logic [fsps_pkg::PAGE_WORDS-1:0] buf_valid_q;
  logic [15:0] buf_rd_q;
  fsps_pkg::fsps_flash_cmd_t flash_cmd_q;

  logic wr_fire;
  logic rd_fire;
  logic wr_ctrl;
  logic wr_store;
  logic wr_load;
  logic cmd_legal;
  logic armed;
  logic store_ok;
  logic store_load;
  logic store_erase;
  logic store_write;
  logic store_lock;
  logic store_reen;
  logic lock_read;
  logic op_done;
  logic buf_clear;
  logic [5:0] wr_word;
  logic [6:0] wr_page;
  logic [4:0] new_cmd;
  fsps_pkg::fsps_ctrl_t ctrl_view;

  // Write channels are taken together; a pending response stalls both
  assign wr_fire = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = 2'b00;
  assign rd_fire = s_axi_arvalid & ~rvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = 2'b00;

  // Register decode; control writes need the low byte lane
  assign wr_ctrl = wr_fire & (s_axi_awaddr == fsps_pkg::OFF_CTRL) &
                   s_axi_wstrb[0];
  assign wr_store = wr_fire & (s_axi_awaddr == fsps_pkg::OFF_STORE);
  assign wr_load = wr_fire & (s_axi_awaddr == fsps_pkg::OFF_LOAD);
  assign new_cmd = s_axi_wdata[4:0];

  // Only the five defined patterns arm the sequencer
  assign cmd_legal = (new_cmd == fsps_pkg::CMD_LOAD) |
                     (new_cmd == fsps_pkg::CMD_ERASE) |
                     (new_cmd == fsps_pkg::CMD_WRITE) |
                     (new_cmd == fsps_pkg::CMD_LOCK) |
                     (new_cmd == fsps_pkg::CMD_REEN);

  // A store is honoured only inside the window and with no EEPROM write
  assign armed = (state_q == fsps_pkg::ST_ARMED);
  assign store_ok = armed & wr_store & ~eeprom_write_busy_bit;
  assign store_load = store_ok & (cmd_q == fsps_pkg::CMD_LOAD);
  assign store_erase = store_ok & (cmd_q == fsps_pkg::CMD_ERASE);
  assign store_write = store_ok & (cmd_q == fsps_pkg::CMD_WRITE);
  assign store_lock = store_ok & (cmd_q == fsps_pkg::CMD_LOCK);
  assign store_reen = store_ok & (cmd_q == fsps_pkg::CMD_REEN);

  // Lock or fuse read: lock-set armed, load window open, no EEPROM write
  assign lock_read = armed & wr_load & (cmd_q == fsps_pkg::CMD_LOCK) &
                     (load_win_q != 3'h0) & ~eeprom_write_busy_bit;

  assign op_done = (state_q == fsps_pkg::ST_BUSY) && (op_cnt_q == 32'h1);
  assign wr_word = z_q[fsps_pkg::WORD_LSB +: fsps_pkg::WORD_BITS];
  assign wr_page = z_q[fsps_pkg::PAGE_LSB +: fsps_pkg::PAGE_BITS];

  // Buffer wipe: after a page write, on re-enable, or on an EEPROM write
  // that lands while words are loaded
  assign buf_clear = (op_done & op_write_q) | store_reen |
                     (eeprom_write_busy_bit & (|buf_valid_q));

  // Control register image; enable bit is high while armed or busy
  always_comb begin
    ctrl_view = '0;
    ctrl_view.irq_en = irq_en_q;
    ctrl_view.busy = busy_flag_q;
    ctrl_view.reen = (cmd_q == fsps_pkg::CMD_REEN);
    ctrl_view.lock = (cmd_q == fsps_pkg::CMD_LOCK);
    ctrl_view.pwrite = (cmd_q == fsps_pkg::CMD_WRITE);
    ctrl_view.erase = (cmd_q == fsps_pkg::CMD_ERASE);
    ctrl_view.store_enable_bit = (state_q != fsps_pkg::ST_IDLE);
  end

  // Interrupt level follows the enable bit being clear, no latching
  assign store_ready_irq = irq_en_q & ~ctrl_view.store_enable_bit;
  assign cpu_halt = halt_q;
  assign rww_read_blocked = busy_flag_q;
  assign flash_rd_addr = z_q[13:1];
  assign flash_cmd = flash_cmd_q;
  assign buf_rd_data = buf_rd_q;

  // Write response channel
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bvalid_q <= 1'b0;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read channel; unmapped offsets read as zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      case (s_axi_araddr)
        fsps_pkg::OFF_CTRL: rdata_q <= {24'h0, ctrl_view};
        fsps_pkg::OFF_POINTER: rdata_q <= {16'h0, z_q};
        fsps_pkg::OFF_DATA: rdata_q <= {16'h0, data_q};
        fsps_pkg::OFF_LOAD: rdata_q <= {24'h0, load_q};
        fsps_pkg::OFF_STATUS: rdata_q <= {26'h0, lock_q};
        default: rdata_q <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Pointer and data working registers, byte lanes honoured
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      z_q <= 16'h0;
      data_q <= 16'h0;
    end else if (wr_fire) begin
      if (s_axi_awaddr == fsps_pkg::OFF_POINTER) begin
        if (s_axi_wstrb[0]) begin
          z_q[7:0] <= s_axi_wdata[7:0];
        end
        if (s_axi_wstrb[1]) begin
          z_q[15:8] <= s_axi_wdata[15:8];
        end
      end
      if (s_axi_awaddr == fsps_pkg::OFF_DATA) begin
        if (s_axi_wstrb[0]) begin
          data_q[7:0] <= s_axi_wdata[7:0];
        end
        if (s_axi_wstrb[1]) begin
          data_q[15:8] <= s_axi_wdata[15:8];
        end
      end
    end
  end

  // Interrupt enable is plain storage, writable in any state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_en_q <= 1'b0;
    end else if (wr_ctrl) begin
      irq_en_q <= s_axi_wdata[fsps_pkg::BIT_IRQ_EN];
    end
  end

  // Sequencer: arm on a legal pattern, open windows, run the operation
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= fsps_pkg::ST_IDLE;
      cmd_q <= fsps_pkg::CMD_NONE;
      win_q <= 3'h0;
      load_win_q <= 3'h0;
      op_cnt_q <= 32'h0;
      page_q <= 7'h0;
      op_write_q <= 1'b0;
      op_erase_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      case (state_q)
        fsps_pkg::ST_IDLE: begin
          // EEPROM write in progress blocks arming entirely
          if (wr_ctrl & cmd_legal & ~eeprom_write_busy_bit) begin
            cmd_q <= new_cmd;
            win_q <= fsps_pkg::STORE_WINDOW;
            load_win_q <= fsps_pkg::LOAD_WINDOW;
            state_q <= fsps_pkg::ST_ARMED;
          end
        end
        fsps_pkg::ST_ARMED: begin
          if (store_erase | store_write | store_lock) begin
            // Latch the page so pointer changes cannot disturb the array
            page_q <= wr_page;
            op_erase_q <= store_erase;
            op_write_q <= store_write;
            op_cnt_q <= PROG_CYCLES;
            // Halt only for page work in the no-READ_WHILE_WRITE_SECTION section
            halt_q <= (store_erase | store_write) &
                      (wr_page >= fsps_pkg::RWW_PAGES);
            state_q <= fsps_pkg::ST_BUSY;
          end else if (store_load | store_reen | lock_read) begin
            cmd_q <= fsps_pkg::CMD_NONE;
            state_q <= fsps_pkg::ST_IDLE;
          end else if (win_q == 3'h1) begin
            // No store in four cycles: enable and command bits fall
            cmd_q <= fsps_pkg::CMD_NONE;
            state_q <= fsps_pkg::ST_IDLE;
          end else begin
            win_q <= win_q - 3'h1;
            if (load_win_q != 3'h0) begin
              load_win_q <= load_win_q - 3'h1;
            end
          end
        end
        fsps_pkg::ST_BUSY: begin
          // Enable bit and command stay up until the count expires
          if (op_done) begin
            cmd_q <= fsps_pkg::CMD_NONE;
            halt_q <= 1'b0;
            op_write_q <= 1'b0;
            op_erase_q <= 1'b0;
            op_cnt_q <= 32'h0;
            state_q <= fsps_pkg::ST_IDLE;
          end else begin
            op_cnt_q <= op_cnt_q - 32'h1;
          end
        end
        default: begin
          state_q <= fsps_pkg::ST_IDLE;
          cmd_q <= fsps_pkg::CMD_NONE;
        end
      endcase
    end
  end

  // Section busy flag: set by READ_WHILE_WRITE_SECTION page work, cleared by re-enable or load.
  // Re-enable is only reachable once idle, so it cannot race the set.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_flag_q <= 1'b0;
    end else if ((store_erase | store_write) &
                 (wr_page < fsps_pkg::RWW_PAGES)) begin
      busy_flag_q <= 1'b1;
    end else if (store_reen | store_load) begin
      busy_flag_q <= 1'b0;
    end
  end

  // Array command pulse at completion; erase and write both use the
  // latched page, so software must keep the two pages the same
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flash_cmd_q <= '0;
    end else begin
      flash_cmd_q.erase <= op_done & op_erase_q;
      flash_cmd_q.write <= op_done & op_write_q;
      flash_cmd_q.page <= page_q;
    end
  end

  // Boot lock bits: a cleared data bit programs, programmed reads zero.
  // Memory lock bits are not reachable by software stores.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_q <= fsps_pkg::LOCK_RESET;
    end else if (store_lock) begin
      lock_q[5:2] <= lock_q[5:2] & data_q[5:2];
    end
  end

  // Load result: lock and fuse reads, else byte-wide flash reads
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      load_q <= 8'h0;
    end else if (lock_read & (z_q == fsps_pkg::Z_LOCK)) begin
      load_q <= {2'b11, lock_q};
    end else if (lock_read & (z_q == fsps_pkg::Z_FUSE_LOW)) begin
      load_q <= fuse_low_byte;
    end else if (lock_read & (z_q == fsps_pkg::Z_FUSE_HIGH)) begin
      load_q <= fuse_high_byte;
    end else if (wr_load & busy_flag_q &
                 (wr_page < fsps_pkg::RWW_PAGES)) begin
      load_q <= 8'hff;
    end else if (wr_load) begin
      load_q <= z_q[0] ? flash_rd_word[15:8] : flash_rd_word[7:0];
    end
  end

  // Temporary page buffer; each entry has its own valid bit so a wipe
  // takes one cycle. A word store arriving with a wipe is dropped.
  genvar gi;
  generate
    for (gi = 0; gi < fsps_pkg::PAGE_WORDS; gi++) begin : g_buf
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          buf_valid_q[gi] <= 1'b0;
        end else if (buf_clear) begin
          buf_valid_q[gi] <= 1'b0;
        end else if (store_load && (wr_word == 6'(gi))) begin
          buf_valid_q[gi] <= 1'b1;
        end
      end
      always_ff @(posedge clk) begin
        if (store_load && (wr_word == 6'(gi))) begin
          buf_mem[gi] <= data_q;
        end
      end
    end
  endgenerate

  // Buffer read-out for the array; empty entries read as erased
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      buf_rd_q <= fsps_pkg::BUF_EMPTY;
    end else if (buf_valid_q[buf_rd_addr]) begin
      buf_rd_q <= buf_mem[buf_rd_addr];
    end else begin
      buf_rd_q <= fsps_pkg::BUF_EMPTY;
    end
  end

endmodule

// >>> tb/fsps_flash_model.sv
// Behavioural flash array and fuse store beside the sequencer
`timescale 1ns/1ns
module fsps_flash_model #(
  parameter logic [7:0] FUSE_LOW = 8'h9e,
  parameter logic [7:0] FUSE_HIGH = 8'h61
) (
  // Array read port
  input wire logic [12:0] flash_rd_addr,
  output logic [15:0] flash_rd_word,
  // Fuse values, a zero bit is programmed
  output logic [7:0] fuse_low_byte,
  output logic [7:0] fuse_high_byte
);
  // Each word carries its address, so a wrong word or byte shows at once
  assign flash_rd_word = {3'h5, flash_rd_addr};
  // Fuses never change from software, so they are plain constants
  assign fuse_low_byte = FUSE_LOW;
  assign fuse_high_byte = FUSE_HIGH;
endmodule

// >>> tb/fsps_sequencer_monitor.sv
// Port checker for the flash self-program sequencer
`timescale 1ns/1ns
module fsps_sequencer_monitor #(
  parameter int unsigned PROG_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sequencer indications
  input wire fsps_pkg::fsps_flash_cmd_t flash_cmd,
  input wire logic cpu_halt,
  input wire logic rww_read_blocked,
  input wire logic store_ready_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [31:0] halt_len_q;
  // Halt length, judged when the halt ends; a reset restarts it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      halt_len_q <= 32'h0;
    end else if (cpu_halt) begin
      halt_len_q <= halt_len_q + 32'h1;
    end else begin
      halt_len_q <= 32'h0;
    end
  end
  AST_HALT_LEN: assert property ($fell(cpu_halt) |->
    halt_len_q + 32'h2 >= PROG_CYCLES && halt_len_q <= PROG_CYCLES + 2)
    else $error("halt length off");
  AST_HALT_CMD: assert property ($fell(cpu_halt) |-> ##[0:2]
    ((flash_cmd.erase || flash_cmd.write) &&
     flash_cmd.page >= fsps_pkg::RWW_PAGES))
    else $error("no array command for halted page");
  AST_CMD_PULSE: assert property ((flash_cmd.erase || flash_cmd.write) |=>
    !(flash_cmd.erase || flash_cmd.write))
    else $error("array command longer than one cycle");
  AST_IRQ_HALT: assert property ($rose(cpu_halt) |->
    (!store_ready_irq)[*8])
    else $error("ready request during halt");
  AST_IRQ_BLOCK: assert property ($rose(rww_read_blocked) |->
    (!store_ready_irq)[*8])
    else $error("ready request while section busy starts");
  AST_BRESP: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready
    |=> s_axi_bvalid && s_axi_bresp == 2'h0)
    else $error("write response missing");
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_RRESP: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && s_axi_rresp == 2'h0)
    else $error("read response missing");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule
bind fsps_sequencer fsps_sequencer_monitor #(.PROG_CYCLES(PROG_CYCLES)) i_mon (
  .clk(clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .flash_cmd(flash_cmd), .cpu_halt(cpu_halt),
  .rww_read_blocked(rww_read_blocked), .store_ready_irq(store_ready_irq));

// >>> tb/test_fsps_sequencer.sv
// Self-checking bench for the flash self-program sequencer
`timescale 1ns/1ns
module test_fsps_sequencer;
  logic clk = 1'b0, reset = 1'b1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready;
  logic rvalid, ee_busy = 1'b0, halt, blocked, irq;
  logic [1:0] bresp, rresp;
  logic [12:0] rd_addr;
  logic [15:0] rd_word, buf_data;
  logic [7:0] fuse_lo, fuse_hi;
  logic [5:0] buf_addr = 6'h0;
  fsps_pkg::fsps_flash_cmd_t fcmd, last_cmd = '0;
  int mismatches = 0, num_checks = 0, cycles = 0;
  logic [31:0] zp [3] = '{32'h0, 32'h1, 32'h3};
  logic [31:0] fx [3] = '{32'h9e, 32'heb, 32'h61};
  logic [31:0] bad [3] = '{32'h07, 32'h0f, 32'h1f};

  fsps_sequencer #(.PROG_CYCLES(40)) i_fsps_sequencer (
    .clk(clk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .eeprom_write_busy_bit(ee_busy),
    .fuse_low_byte(fuse_lo), .fuse_high_byte(fuse_hi),
    .flash_rd_addr(rd_addr), .flash_rd_word(rd_word), .flash_cmd(fcmd),
    .buf_rd_addr(buf_addr), .buf_rd_data(buf_data), .cpu_halt(halt),
    .rww_read_blocked(blocked), .store_ready_irq(irq));
  fsps_flash_model #(.FUSE_LOW(8'h9e), .FUSE_HIGH(8'h61)) i_fsps_flash_model (
    .flash_rd_addr(rd_addr), .flash_rd_word(rd_word),
    .fuse_low_byte(fuse_lo), .fuse_high_byte(fuse_hi));

  always #10 clk = ~clk;

  // Keep the last array command, so the page it used can be checked later
  always @(posedge clk) begin
    if (fcmd.erase || fcmd.write) begin
      last_cmd <= fcmd;
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A hung handshake ends the run here
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // Response ready comes a cycle late so a stalled response is exercised
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input string what);
    logic [31:0] v;
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    v = rdata;
    rready <= 1'b0;
    chk(what, v, e);
  endtask

  task automatic bchk(input logic [5:0] a, input logic [15:0] e);
    buf_addr <= a;
    repeat (2) @(posedge clk);
    #1;
    chk("buffer word", {16'h0, buf_data}, {16'h0, e});
  endtask

  // Control write then store: the store lands three edges after the control
  task automatic op(input logic [31:0] c);
    wr(fsps_pkg::OFF_CTRL, c);
    wr(fsps_pkg::OFF_STORE, 32'h0);
    #1;
  endtask

  // Poll until the enable bit drops; the poll count bounds the wait.
  // Callers leave the ready request enabled, so it shows in the control
  task automatic wait_done();
    for (int i = 0; i < 60 && !(halt === 1'b0 && irq === 1'b1); i++) begin
      @(posedge clk);
    end
    rchk(fsps_pkg::OFF_CTRL, 32'h80, "idle after operation");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rchk(fsps_pkg::OFF_CTRL, 32'h0, "control at reset");
    rchk(fsps_pkg::OFF_STATUS, 32'h3f, "lock bits at reset");
    rchk(8'hfc, 32'h0, "unmapped read");
    // Boot lock programming: zero data bits 4 and 2 program those bits
    wr(fsps_pkg::OFF_DATA, 32'heb);
    op(32'h89);
    chk("no halt on lock", {31'h0, halt}, 32'h0);
    wait_done();
    rchk(fsps_pkg::OFF_STATUS, 32'h2b, "lock bits");
    // Fuse and lock reads through the load window
    for (int i = 0; i < 3; i++) begin
      wr(fsps_pkg::OFF_POINTER, zp[i]);
      wr(fsps_pkg::OFF_CTRL, 32'h09);
      wr(fsps_pkg::OFF_LOAD, 32'h0);
      rchk(fsps_pkg::OFF_LOAD, fx[i], "fuse or lock");
      rchk(fsps_pkg::OFF_CTRL, 32'h0, "lock-set cleared");
    end
    // Plain loads pick the byte with pointer bit zero
    for (int b = 0; b < 2; b++) begin
      wr(fsps_pkg::OFF_POINTER, 32'h0202 | b);
      wr(fsps_pkg::OFF_LOAD, 32'h0);
      rchk(fsps_pkg::OFF_LOAD, b ? 32'ha1 : 32'h01, "byte load");
    end
    // One buffer word, then erase of a read-while-write page
    wr(fsps_pkg::OFF_POINTER, 32'h000a);
    wr(fsps_pkg::OFF_DATA, 32'h1234);
    op(32'h01);
    bchk(6'h5, 16'h1234);
    bchk(6'h4, 16'hffff);
    wr(fsps_pkg::OFF_POINTER, 32'h0100);
    op(32'h83);
    chk("request low while busy", {31'h0, irq}, 32'h0);
    chk("section blocked", {31'h0, blocked}, 32'h1);
    wr(fsps_pkg::OFF_POINTER, 32'h3900);
    #1;
    chk("latched page", {31'h0, halt}, 32'h0);
    // Pointer now names another page, so an unlatched page shows below
    wr(fsps_pkg::OFF_POINTER, 32'h0181);
    wr(fsps_pkg::OFF_LOAD, 32'h0);
    rchk(fsps_pkg::OFF_LOAD, 32'hff, "blocked read");
    repeat (40) @(posedge clk);
    #1;
    chk("ready request", {31'h0, irq}, 32'h1);
    chk("erased page", {23'h0, last_cmd}, 32'h102);
    rchk(fsps_pkg::OFF_CTRL, 32'hc0, "busy flag held");
    op(32'h11);
    chk("section released", {31'h0, blocked}, 32'h0);
    bchk(6'h5, 16'hffff);
    // Erase then write one no-read-while-write page; both halt the core
    wr(fsps_pkg::OFF_POINTER, 32'h0004);
    wr(fsps_pkg::OFF_DATA, 32'hbeef);
    op(32'h01);
    wr(fsps_pkg::OFF_POINTER, 32'h3900);
    op(32'h03);
    repeat (45) @(posedge clk);
    op(32'h85);
    chk("halt on write", {31'h0, halt}, 32'h1);
    repeat (50) @(posedge clk);
    rchk(fsps_pkg::OFF_CTRL, 32'h80, "write done");
    chk("written page", {23'h0, last_cmd}, 32'h0f2);
    bchk(6'h2, 16'hffff);
    // A late store and unknown patterns start nothing
    wr(fsps_pkg::OFF_CTRL, 32'h03);
    repeat (6) @(posedge clk);
    wr(fsps_pkg::OFF_STORE, 32'h0);
    rchk(fsps_pkg::OFF_CTRL, 32'h0, "window closed");
    for (int i = 0; i < 3; i++) begin
      op(bad[i]);
      chk("unknown pattern", {31'h0, halt}, 32'h0);
      rchk(fsps_pkg::OFF_CTRL, 32'h0, "pattern ignored");
    end
    // An EEPROM write wipes the buffer and blocks lock reads
    wr(fsps_pkg::OFF_POINTER, 32'h0006);
    wr(fsps_pkg::OFF_DATA, 32'h55aa);
    op(32'h01);
    bchk(6'h3, 16'h55aa);
    ee_busy <= 1'b1;
    bchk(6'h3, 16'hffff);
    wr(fsps_pkg::OFF_POINTER, 32'h0001);
    wr(fsps_pkg::OFF_CTRL, 32'h09);
    wr(fsps_pkg::OFF_LOAD, 32'h0);
    rchk(fsps_pkg::OFF_LOAD, 32'ha0, "lock read refused");
    ee_busy <= 1'b0;
    results();
  end
endmodule
